// ===== core/bf_pkg.sv
package bf_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ     = 20_000_000;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES_DEF = CLK_FREQ_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_CNT_W      = 18;
  // delay in ticks of 10 ms: 0.06 s .. 60.00 s, default 0.25 s
  localparam int unsigned DELAY_W         = 13;
  localparam logic [12:0] DELAY_MIN       = 13'h0006;
  localparam logic [12:0] DELAY_MAX       = 13'h1770;
  localparam logic [12:0] DELAY_RST       = 13'h0019;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] DELAY_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

  // control fields
  localparam int unsigned CFG_EN_BIT   = 0;
  localparam int unsigned FN_ON_BIT    = 1;
  localparam int unsigned CHK_BIT      = 2;
  localparam int unsigned AUX_LSB      = 3;
  localparam int unsigned RETRIP_BIT   = 5;
  localparam logic [5:0]  CTRL_RST     = 6'h00;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // auxiliary contact wiring
  typedef enum logic [1:0] {
    AUX_BOTH, AUX_NO_ONLY, AUX_NC_ONLY, AUX_NONE
  } aux_mode_t;
endpackage : bf_pkg

// ===== core/delay_timer_if.sv
interface delay_timer_if;
  logic        run;
  logic        tick;
  logic [12:0] delay;
  logic        pickup;
  logic        trip;

  modport timer (input run, input tick, input delay, output pickup, output trip);
  modport ctrl  (output run, output tick, output delay, input pickup, input trip);
endinterface : delay_timer_if

// ===== core/source_delay_timer.sv
module source_delay_timer
  import bf_pkg::*;
(
  // clock and reset
  input  wire logic     mclk_i,
  input  wire logic     rst_n_i,
  // timer link
  delay_timer_if.timer  tmr
);

  typedef struct packed {
    logic [12:0] count;
    logic        pickup;
    logic        trip;
  } tmr_state_t;

  tmr_state_t st_ff;
  tmr_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!tmr.run) begin
      nxt_st = '0;
    end else if (!st_ff.pickup) begin
      nxt_st.pickup = 1'b1;
      nxt_st.count  = tmr.delay;
    end else if (!st_ff.trip && tmr.tick) begin
      if (st_ff.count <= 13'h0001) begin
        nxt_st.trip  = 1'b1;
        nxt_st.count = 13'h0000;
      end else begin
        nxt_st.count = st_ff.count - 13'h0001;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tmr.pickup = st_ff.pickup;
  assign tmr.trip   = st_ff.trip;

endmodule : source_delay_timer

// ===== core/breaker_failure_monitor.sv
// Contract
// - Initiation raises a pickup and starts the delay; expiry raises the trip.
// - Internal and external sources each have own pickup, timer and trip, plus a common trip.
// - The current criterion holds when any of the three phase flags is set.
// - Contact wiring may be both contacts, normally-open only, normally-closed only or none.
// - With contact check on, current and contacts judge the breaker; off, current only.
// - If the criterion that picked up fails before expiry, the timer resets without a trip; the code resets only once current and checked contacts both fail.
// - The external initiate must stay high the whole delay, else that source resets.
// - The function has an on/off setting, a block input and off/blocked/active status.
// - The delay is settable from 0.06 s to 60.00 s and defaults to 0.25 s.
// - With the configuration enable cleared the function has no effect.
// - Normally-open input low means breaker open; normally-closed low means closed.
// - Pickup of either source may be routed to the own breaker retrip output.
// - Breaker state seen by the contacts before initiation is used in the decision.
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
module breaker_failure_monitor
  import bf_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // plant and initiation inputs
  input  wire logic [2:0]  phase_over_i,
  input  wire logic        internal_initiate_i,
  input  wire logic        external_initiate_input_i,
  input  wire logic        block_input_i,
  input  wire logic        aux_no_i,
  input  wire logic        aux_nc_i,
  // indications and trips
  output logic             internal_source_pickup_o,
  output logic             external_source_pickup_o,
  output logic             internal_source_trip_o,
  output logic             external_source_trip_o,
  output logic             common_failure_trip_o,
  output logic             own_breaker_retrip_o,
  output logic             status_switched_off_o,
  output logic             status_blocked_o,
  output logic             status_active_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic                  cfg_en;
    logic                  fn_on;
    logic                  chk;
    aux_mode_t             aux_mode;
    logic                  retrip_en;
    logic [12:0]           delay;
    logic [3:0]            irq_stat;
    logic [3:0]            irq_mask;
    logic [TICK_CNT_W-1:0] div;
    logic                  tick;
    logic                  ap_wr;
    logic [7:0]            ap_addr;
    logic [31:0]           rdata;
    logic                  init_int_d;
    logic                  init_ext_d;
    logic                  pre_int;
    logic                  pre_ext;
    logic [3:0]            ev_prev;
    logic                  common_trip;
    logic                  retrip;
    logic                  st_off;
    logic                  st_blk;
    logic                  st_act;
  } bf_state_t;

  bf_state_t  st_ff;
  bf_state_t  nxt_st;
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  delay_timer_if int_tmr ();
  delay_timer_if ext_tmr ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [12:0] clamp_delay(input logic [12:0] d);
    if (d < DELAY_MIN) begin
      return DELAY_MIN;
    end else if (d > DELAY_MAX) begin
      return DELAY_MAX;
    end
    return d;
  endfunction : clamp_delay

  // breaker still closed as judged by current, and by contacts if checked
  function automatic logic still_closed(input logic cur, input logic chk,
                                        input logic cont_ok, input logic pre);
    return cur | (chk & cont_ok & pre);
  endfunction : still_closed

  function automatic logic [31:0] read_mux(input bf_state_t s, input logic [7:0] a,
                                           input logic [3:0] live);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      CTRL_OFS:     r[5:0]  = {s.retrip_en, s.aux_mode, s.chk, s.fn_on, s.cfg_en};
      DELAY_OFS:    r[12:0] = s.delay;
      STATUS_OFS:   r[7:0]  = {s.st_act, s.st_blk, s.st_off, s.common_trip, live};
      IRQ_STAT_OFS: r[3:0]  = s.irq_stat;
      IRQ_MASK_OFS: r[3:0]  = s.irq_mask;
      default:      r       = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ---------------------------------------------------------------
  // breaker judgement
  // ---------------------------------------------------------------
  logic       on_cfg;
  logic       active;
  logic       cur_met;
  logic       cont_closed;
  logic       cont_used;
  logic       int_rise;
  logic       ext_rise;
  logic       pre_int_now;
  logic       pre_ext_now;
  logic [3:0] live;
  logic [3:0] events;
  logic       ap_take;

  assign on_cfg  = st_ff.cfg_en & st_ff.fn_on;
  assign active  = on_cfg & ~block_input_i;
  assign cur_met = |phase_over_i;

  // no high while closed, nc high while open
  always_comb begin
    cont_closed = 1'b0;
    cont_used   = 1'b1;
    unique case (st_ff.aux_mode)
      AUX_BOTH:    cont_closed = aux_no_i | ~aux_nc_i;
      AUX_NO_ONLY: cont_closed = aux_no_i;
      AUX_NC_ONLY: cont_closed = ~aux_nc_i;
      AUX_NONE:    cont_used   = 1'b0;
    endcase
  end

  // contact state caught at initiation; a breaker already open then
  // cannot hold the scheme up through a stuck contact afterwards
  assign int_rise    = internal_initiate_i & ~st_ff.init_int_d;
  assign ext_rise    = external_initiate_input_i & ~st_ff.init_ext_d;
  assign pre_int_now = int_rise ? cont_closed : st_ff.pre_int;
  assign pre_ext_now = ext_rise ? cont_closed : st_ff.pre_ext;

  assign int_tmr.run = active & internal_initiate_i
                     & still_closed(cur_met, st_ff.chk, cont_used & cont_closed, pre_int_now);
  assign ext_tmr.run = active & external_initiate_input_i
                     & still_closed(cur_met, st_ff.chk, cont_used & cont_closed, pre_ext_now);
  assign int_tmr.tick  = st_ff.tick;
  assign ext_tmr.tick  = st_ff.tick;
  assign int_tmr.delay = st_ff.delay;
  assign ext_tmr.delay = st_ff.delay;

  source_delay_timer u_int_tmr (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .tmr     (int_tmr.timer)
  );

  source_delay_timer u_ext_tmr (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .tmr     (ext_tmr.timer)
  );

  assign live    = {ext_tmr.trip, int_tmr.trip, ext_tmr.pickup, int_tmr.pickup};
  assign events  = live & ~st_ff.ev_prev;
  assign ap_take = hsel_i & htrans_i[1] & hready_i;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // tick divider
    nxt_st.tick = 1'b0;
    if (st_ff.div == TICK_LAST) begin
      nxt_st.div  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + TICK_CNT_W'(1);
    end
    nxt_st.init_int_d = internal_initiate_i;
    nxt_st.init_ext_d = external_initiate_input_i;
    nxt_st.pre_int    = pre_int_now;
    nxt_st.pre_ext    = pre_ext_now;
    nxt_st.ev_prev    = live;
    // outputs
    nxt_st.common_trip = int_tmr.trip | ext_tmr.trip;
    nxt_st.retrip      = st_ff.retrip_en & (int_tmr.pickup | ext_tmr.pickup);
    nxt_st.st_off      = ~on_cfg;
    nxt_st.st_blk      = on_cfg & block_input_i;
    nxt_st.st_act      = active;
    // data phase write
    nxt_st.irq_stat = st_ff.irq_stat;
    if (st_ff.ap_wr) begin
      unique case (st_ff.ap_addr)
        CTRL_OFS: begin
          nxt_st.cfg_en    = hwdata_i[CFG_EN_BIT];
          nxt_st.fn_on     = hwdata_i[FN_ON_BIT];
          nxt_st.chk       = hwdata_i[CHK_BIT];
          nxt_st.aux_mode  = aux_mode_t'(hwdata_i[AUX_LSB +: 2]);
          nxt_st.retrip_en = hwdata_i[RETRIP_BIT];
        end
        DELAY_OFS:    nxt_st.delay    = clamp_delay(hwdata_i[12:0]);
        IRQ_STAT_OFS: nxt_st.irq_stat = st_ff.irq_stat & ~hwdata_i[3:0];
        IRQ_MASK_OFS: nxt_st.irq_mask = hwdata_i[3:0];
        default:      nxt_st.irq_stat = st_ff.irq_stat;
      endcase
    end
    // set beats a same-cycle clear
    nxt_st.irq_stat = nxt_st.irq_stat | events;
    // address phase
    nxt_st.ap_wr = 1'b0;
    if (ap_take) begin
      nxt_st.ap_wr   = hwrite_i;
      nxt_st.ap_addr = haddr_i[7:0] & {8{haddr_i[31:8] == 24'h000000}};
      if (haddr_i[31:8] != 24'h000000) begin
        nxt_st.ap_addr = 8'hFF;
      end
      if (!hwrite_i) begin
        nxt_st.rdata = (haddr_i[31:8] == 24'h000000)
                     ? read_mux(st_ff, haddr_i[7:0], live) : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_ff           <= '0;
      st_ff.cfg_en    <= CTRL_RST[CFG_EN_BIT];
      st_ff.fn_on     <= CTRL_RST[FN_ON_BIT];
      st_ff.delay     <= DELAY_RST;
      st_ff.irq_mask  <= IRQ_MASK_RST;
      st_ff.aux_mode  <= AUX_BOTH;
      st_ff.st_off    <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata_o                 = st_ff.rdata;
  assign hreadyout_o              = 1'b1;
  assign hresp_o                  = 1'b0;
  assign internal_source_pickup_o = int_tmr.pickup;
  assign external_source_pickup_o = ext_tmr.pickup;
  assign internal_source_trip_o   = int_tmr.trip;
  assign external_source_trip_o   = ext_tmr.trip;
  assign common_failure_trip_o    = st_ff.common_trip;
  assign own_breaker_retrip_o     = st_ff.retrip;
  assign status_switched_off_o    = st_ff.st_off;
  assign status_blocked_o         = st_ff.st_blk;
  assign status_active_o          = st_ff.st_act;
  assign irq_o                    = |(st_ff.irq_stat & st_ff.irq_mask);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  pickup_start_a: assert property ($rose(int_tmr.run) |=> internal_source_pickup_o)
    else $error("internal pickup did not follow initiation");

  common_trip_a: assert property ((int_tmr.trip || ext_tmr.trip) |=> common_failure_trip_o)
    else $error("common trip missing after source trip");

  any_phase_a: assert property ((active && internal_initiate_i && cur_met && !int_tmr.pickup)
    |=> internal_source_pickup_o)
    else $error("phase current did not pick up");

  current_only_a: assert property ((!st_ff.chk && !cur_met) |=> !internal_source_pickup_o)
    else $error("contacts used with contact check off");

  drop_out_a: assert property (!int_tmr.run |=> !internal_source_pickup_o && !internal_source_trip_o)
    else $error("internal timer not reset on drop-out");

  ext_drop_a: assert property ($fell(external_initiate_input_i)
    |=> !external_source_pickup_o && !external_source_trip_o)
    else $error("external source held after initiate fell");

  block_hold_a: assert property (block_input_i |=> ##1 (live == 4'h0))
    else $error("outputs active while blocked");

  status_one_a: assert property ($onehot({status_switched_off_o, status_blocked_o,
    status_active_o}))
    else $error("status indications not exclusive");

  delay_range_a: assert property (st_ff.delay >= DELAY_MIN && st_ff.delay <= DELAY_MAX)
    else $error("delay outside legal range");

  cfg_off_a: assert property (!st_ff.cfg_en |=> status_switched_off_o && !int_tmr.pickup)
    else $error("function acts while disabled");

  retrip_a: assert property ((st_ff.retrip_en && int_tmr.pickup) |=> own_breaker_retrip_o)
    else $error("retrip missing");

  no_early_trip_a: assert property ($rose(internal_source_pickup_o) |-> !internal_source_trip_o
    ##1 !internal_source_trip_o)
    else $error("trip together with pickup");

  irq_level_a: assert property ((st_ff.irq_stat & st_ff.irq_mask) != 4'h0 |-> irq_o)
    else $error("irq low with unmasked status");

  int_trip_c: cover property ($rose(internal_source_trip_o));
  ext_trip_c: cover property ($rose(external_source_trip_o));
  dropout_c:  cover property (internal_source_pickup_o && !internal_source_trip_o
    ##1 !internal_source_pickup_o);
  block_c:    cover property (internal_source_pickup_o ##1 block_input_i);

endmodule : breaker_failure_monitor

// ===== dv/breaker_model.sv
module breaker_model (
  // clock
  input  wire logic       mclk_i,
  // commands from the bench
  input  wire logic       trip_i,
  input  wire logic       close_i,
  input  wire logic [7:0] open_dly_i,
  input  wire logic [2:0] fault_i,
  // breaker plant
  output logic      [2:0] phase_over_o,
  output logic            aux_no_o,
  output logic            aux_nc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // mechanism
  // ---------------------------------------------------------------
  logic       closed_ff = 1'b1;
  logic [7:0] cnt_ff    = 8'h00;
  // 8'hFF stands for a stuck breaker: it never opens within a test
  always @(posedge mclk_i) begin
    if (close_i) begin
      closed_ff <= 1'b1;
      cnt_ff    <= 8'h00;
    end else if (trip_i && closed_ff && open_dly_i != 8'hFF) begin
      if (cnt_ff == open_dly_i) begin
        closed_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
  // current flows only while the poles are closed
  assign phase_over_o = closed_ff ? fault_i : 3'h0;
  assign aux_no_o     = closed_ff;
  assign aux_nc_o     = !closed_ff;
endmodule : breaker_model

// ===== dv/breaker_failure_monitor_test.sv
module breaker_failure_monitor_test
  import bf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        mclk_i     = 1'b0;
  logic        arst_n_i   = 1'b0;
  logic [1:0]  htrans     = 2'h0;
  logic        hwrite     = 1'b0;
  logic [31:0] haddr      = 32'h0;
  logic [31:0] hwdata     = 32'h0;
  logic        ini        = 1'b0;
  logic        ine        = 1'b0;
  logic        blk        = 1'b0;
  logic        brk_close  = 1'b0;
  logic [7:0]  odly       = 8'hFF;
  logic [2:0]  fault      = 3'h0;
  logic        rt_en      = 1'b0;
  logic [31:0] got;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc_cnt    = 0;
  int          seed       = 99936;
  event        rd_ev;
  wire logic [31:0] hrdata;
  wire logic        hready, hresp, ipu, epu, itr, etr, ctr, rtr, soff, sblk, sact, irq;
  wire logic [2:0]  po;
  wire logic        ano, anc;

  initial begin
    forever #25 mclk_i = !mclk_i;
  end

  breaker_failure_monitor #(.TICK_CYCLES(4)) DUT (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .phase_over_i(po), .internal_initiate_i(ini), .external_initiate_input_i(ine),
    .block_input_i(blk), .aux_no_i(ano), .aux_nc_i(anc),
    .internal_source_pickup_o(ipu), .external_source_pickup_o(epu),
    .internal_source_trip_o(itr), .external_source_trip_o(etr),
    .common_failure_trip_o(ctr), .own_breaker_retrip_o(rtr),
    .status_switched_off_o(soff), .status_blocked_o(sblk), .status_active_o(sact),
    .irq_o(irq));

  breaker_model plant (
    .mclk_i(mclk_i), .trip_i(ini | ine), .close_i(brk_close), .open_dly_i(odly),
    .fault_i(fault), .phase_over_o(po), .aux_no_o(ano), .aux_nc_o(anc));

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // a hang in a handshake wait ends here
  always @(posedge mclk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    forever begin
      @(rd_ev);
      check(got, exp_q.pop_front());
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk_i);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_i); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    exp_q.push_back(e);
    got = q;
    -> rd_ev;
  endtask : rd

  // pins must agree with the status word they mirror; status is steady here
  task automatic st(input logic [31:0] e);
    rd(STATUS_OFS, e);
    check({23'h0, hresp, sact, sblk, soff, ctr, etr, itr, epu, ipu}, e);
  endtask : st

  // closes the breaker so each shot starts from a closed breaker with the given phase faults
  task automatic prep(input logic [7:0] od, input logic [2:0] ph);
    brk_close <= 1'b1;
    cyc(1);
    brk_close <= 1'b0;
    odly      <= od;
    fault     <= ph;
  endtask : prep

  task automatic shot(input logic i, input logic e, input logic [7:0] od, input logic [2:0] ph,
                      input logic [31:0] e_pu, input logic [31:0] e_end);
    prep(od, ph);
    ini <= i;
    ine <= e;
    cyc(3);
    st(e_pu);
    check({31'h0, rtr}, {31'h0, rt_en & (|e_pu[1:0])});
    cyc(40);
    st(e_end);
    ini <= 1'b0;
    ine <= 1'b0;
    cyc(3);
  endtask : shot

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [2:0] ph;
    cyc(20);
    arst_n_i <= 1'b1;
    cyc(3);
    rd(CTRL_OFS, 32'h0);
    rd(DELAY_OFS, {19'h0, DELAY_RST});
    st(32'h20);
    rd(IRQ_MASK_OFS, {28'h0, IRQ_MASK_RST});
    rd(8'h40, 32'h0);
    wr(DELAY_OFS, 32'h0);
    rd(DELAY_OFS, {19'h0, DELAY_MIN});
    wr(DELAY_OFS, 32'hFFFF);
    rd(DELAY_OFS, {19'h0, DELAY_MAX});
    wr(DELAY_OFS, 32'h6);
    wr(STATUS_OFS, 32'hFF);
    st(32'h20);
    $display("test reset and settings done");
    wr(CTRL_OFS, 32'h2);
    st(32'h20);
    wr(CTRL_OFS, 32'h1);
    st(32'h20);
    wr(CTRL_OFS, 32'h3);
    st(32'h80);
    blk <= 1'b1;
    cyc(2);
    st(32'h40);
    blk <= 1'b0;
    cyc(2);
    $display("test status done");
    wr(IRQ_STAT_OFS, 32'hF);
    wr(IRQ_MASK_OFS, 32'h4);
    shot(1'b1, 1'b0, 8'hFF, 3'h1, 32'h81, 32'h95);
    check({31'h0, irq}, 32'h1);
    rd(IRQ_STAT_OFS, 32'h5);
    wr(IRQ_STAT_OFS, 32'h4);
    rd(IRQ_STAT_OFS, 32'h1);
    check({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    rt_en = 1'b1;
    wr(CTRL_OFS, 32'h23);
    for (int k = 0; k < 3; k++) begin
      ph = 3'($random(seed));
      if (ph == 3'h0) ph = 3'h4;
      shot(1'b1, 1'b0, 8'hFF, ph, 32'h81, 32'h95);
    end
    shot(1'b1, 1'b0, 8'h0C, 3'h7, 32'h81, 32'h80);
    shot(1'b0, 1'b1, 8'hFF, 3'h2, 32'h82, 32'h9A);
    shot(1'b1, 1'b1, 8'hFF, 3'h1, 32'h83, 32'h9F);
    $display("test current criterion done");
    prep(8'hFF, 3'h1);
    ine <= 1'b1;
    cyc(16);
    ine <= 1'b0;
    cyc(1);
    ine <= 1'b1;
    cyc(12);
    st(32'h82);
    cyc(30);
    st(32'h9A);
    ine <= 1'b0;
    prep(8'hFF, 3'h1);
    ini <= 1'b1;
    cyc(8);
    blk <= 1'b1;
    cyc(2);
    st(32'h40);
    check({31'h0, rtr}, 32'h0);
    cyc(30);
    st(32'h40);
    ini <= 1'b0;
    blk <= 1'b0;
    cyc(3);
    $display("test external and block done");
    rt_en = 1'b0;
    wr(CTRL_OFS, 32'h2);
    shot(1'b1, 1'b0, 8'hFF, 3'h1, 32'h20, 32'h20);
    wr(CTRL_OFS, 32'h3);
    shot(1'b1, 1'b0, 8'hFF, 3'h0, 32'h80, 32'h80);
    for (int m = 0; m < 4; m++) begin
      wr(CTRL_OFS, 32'h7 | (m << 3));
      shot(1'b1, 1'b0, 8'hFF, 3'h0, (m == 3) ? 32'h80 : 32'h81,
           (m == 3) ? 32'h80 : 32'h95);
    end
    wr(CTRL_OFS, 32'h7);
    shot(1'b1, 1'b0, 8'h0C, 3'h0, 32'h81, 32'h80);
    $display("test contact check done");
    complete_run();
  end
endmodule : breaker_failure_monitor_test
